// ==== hw/ddi_map.svh ====
/*
 * Constants of the DDR3 initialisation and mode register block: field
 * positions, reset values, CK-cycle waits and the status port map.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef DDI_MAP_SVH
`define DDI_MAP_SVH

// Mode register field positions and command address bits
`define DDI_MR0_DLL_RST_BIT  8
`define DDI_MR0_BL_LO        0
`define DDI_MR1_RTT_B0       2
`define DDI_MR1_RTT_B1       6
`define DDI_MR1_RTT_B2       9
`define DDI_ADDR_OTF_BIT     12
`define DDI_ADDR_ZQ_LONG_BIT 10

// Reset values
`define DDI_MR_RST           16'h0000
`define DDI_CTRL_RST         8'h01

// Waits in CK cycles
`define DDI_TDLLK_CK         10'h200
`define DDI_TZQINIT_CK       10'h200
`define DDI_TMOD_CK          10'h00c

// Status port indexes
`define DDI_REG_STATUS       3'h0
`define DDI_REG_MR0          3'h1
`define DDI_REG_MR1          3'h2
`define DDI_REG_MR2          3'h3
`define DDI_REG_MR3          3'h4
`define DDI_REG_CTRL         3'h5

`endif

// ==== hw/ddi_pkg.sv ====
/*
 * Types shared by the initialisation block and its burst column unit.
 * Assumes ddi_map.svh on the include path.
 */
package ddi_pkg;
   `include "ddi_map.svh"

   typedef enum logic [1:0] {DDI_BL_FIX8, DDI_BL_OTF, DDI_BL_FIX4, DDI_BL_RSVD} ddi_bl_t;

   typedef enum logic [1:0] {DDI_ST_RESET, DDI_ST_CKE_LOW, DDI_ST_INIT, DDI_ST_READY} ddi_state_t;

   typedef enum logic [2:0] {DDI_CMD_NOP, DDI_CMD_MRS, DDI_CMD_ZQCL, DDI_CMD_READ,
                             DDI_CMD_WRITE, DDI_CMD_OTHER} ddi_cmd_t;
endpackage : ddi_pkg

// ==== hw/ddi_burst_col.sv ====
/*
 * Burst column generator: given the captured start column, the burst
 * length and the beat number, yields the column of that beat.
 * Assumes the caller steps beat_i once per CK cycle of the burst.
 */
module ddi_burst_col
   import ddi_pkg::*;
(
   input  wire logic [9:0] start_col_i,
   input  wire logic       len8_i,
   input  wire logic [2:0] beat_i,
   output logic      [9:0] col_o
);

   logic [2:0] low_sum;

   assign low_sum = start_col_i[2:0] + beat_i;

   // Low bits pick the start, the rest fixes the block; wrap stays inside
   always_comb
   begin
      if (len8_i)
         col_o = {start_col_i[9:3], low_sum};
      else
         col_o = {start_col_i[9:2], low_sum[1:0]};
   end

endmodule : ddi_burst_col

// ==== hw/ddi_init_core.sv ====
/*
 * DDR3 device-side power-up sequencing, mode registers, DLL lock and ZQ
 * calibration timers, termination gating and burst column stepping.
 * Assumes all pins arrive asynchronously, CK slower than core_clk_i/4.
 */
//////////////////////////////////////////////////////////////////////////////
module ddi_init_core
   import ddi_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ck_i,
   input  wire logic        reset_n_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic        odt_i,
   input  wire logic [2:0]  ba_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   output logic             term_en_o,
   output logic             mod_busy_o,
   output logic             dll_locked_o,
   output logic             zq_done_o,
   output logic             ready_o,
   output logic             burst_active_o,
   output logic      [9:0]  burst_col_o
);

   localparam int PW = 27;

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, accept a bit once stages 2 and 3 agree
   logic [PW-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
   logic          ck_prev_reg;
   logic          ck_rise;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         pin_reg <= '0;
      end
      else
      begin
         s1_reg  <= {ck_i, reset_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i,
                     ba_i, addr_i};
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (pin_reg & (s2_reg ^ s3_reg));
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         ck_prev_reg <= 1'b0;
      else
         ck_prev_reg <= pin_reg[26];
   end

   assign ck_rise = pin_reg[26] & ~ck_prev_reg;

   logic        rst_n_f, cke_f, odt_f;
   logic [2:0]  ba_f;
   logic [15:0] addr_f;
   ddi_cmd_t    cmd;

   assign rst_n_f = pin_reg[25];
   assign cke_f   = pin_reg[24];
   assign odt_f   = pin_reg[19];
   assign ba_f    = pin_reg[18:16];
   assign addr_f  = pin_reg[15:0];

   function automatic ddi_cmd_t decode_cmd(input logic [3:0] c);
      unique case (c)
         4'h0:    decode_cmd = DDI_CMD_MRS;
         4'h6:    decode_cmd = DDI_CMD_ZQCL;
         4'h5:    decode_cmd = DDI_CMD_READ;
         4'h4:    decode_cmd = DDI_CMD_WRITE;
         4'h7:    decode_cmd = DDI_CMD_NOP;
         default: decode_cmd = c[3] ? DDI_CMD_NOP : DDI_CMD_OTHER;
      endcase
   endfunction : decode_cmd

   assign cmd = decode_cmd(pin_reg[23:20]);

   //////////////////////////////////////////////////////////////////////////
   // Power-up state: commands count only on CK edges with CKE high
   ddi_state_t state_reg;
   logic       edge_on;
   logic       zq_cmd;

   assign edge_on = ck_rise & rst_n_f & cke_f;
   assign zq_cmd  = edge_on & (cmd == DDI_CMD_ZQCL) & addr_f[`DDI_ADDR_ZQ_LONG_BIT];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         state_reg <= DDI_ST_RESET;
      else if (!rst_n_f)
         state_reg <= DDI_ST_RESET;
      else
         unique case (state_reg)
            DDI_ST_RESET:   state_reg <= DDI_ST_CKE_LOW;
            DDI_ST_CKE_LOW: if (edge_on) state_reg <= DDI_ST_INIT;
            DDI_ST_INIT:    if (ready_o) state_reg <= DDI_ST_READY;
            DDI_ST_READY:   state_reg <= DDI_ST_READY;
         endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Mode registers; cleared only by reset, DLL reset bit self-clears
   logic [15:0] mr_reg [4];
   logic        mrs_hit;
   logic        dll_start_reg;

   assign mrs_hit = edge_on & (cmd == DDI_CMD_MRS) & ~ba_f[2];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || !rst_n_f)
      begin
         for (int i = 0; i < 4; i++)
            mr_reg[i] <= `DDI_MR_RST;
         dll_start_reg <= 1'b0;
      end
      else
      begin
         dll_start_reg <= 1'b0;
         if (mrs_hit)
            // Only the addressed mode register moves; no array state is touched
            mr_reg[ba_f[1:0]] <= addr_f;
         else if (mr_reg[0][`DDI_MR0_DLL_RST_BIT])
         begin
            mr_reg[0][`DDI_MR0_DLL_RST_BIT] <= 1'b0;
            dll_start_reg <= 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // CK-cycle timers: tMOD, tDLLK, tZQinit
   logic [9:0] mod_cnt_reg, dll_cnt_reg, zq_cnt_reg;
   logic       zq_run_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || !rst_n_f)
         mod_cnt_reg <= '0;
      else if (mrs_hit)
         mod_cnt_reg <= `DDI_TMOD_CK;
      else if (ck_rise && mod_cnt_reg != 10'h000)
         mod_cnt_reg <= mod_cnt_reg - 10'h001;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || !rst_n_f)
      begin
         dll_cnt_reg  <= '0;
         dll_locked_o <= 1'b0;
      end
      else if (dll_start_reg)
      begin
         dll_cnt_reg  <= `DDI_TDLLK_CK;
         dll_locked_o <= 1'b0;
      end
      else if (edge_on && dll_cnt_reg != 10'h000)
      begin
         dll_cnt_reg  <= dll_cnt_reg - 10'h001;
         dll_locked_o <= (dll_cnt_reg == 10'h001);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || !rst_n_f)
      begin
         zq_cnt_reg <= '0;
         zq_run_reg <= 1'b0;
         zq_done_o  <= 1'b0;
      end
      else if (zq_cmd)
      begin
         zq_cnt_reg <= `DDI_TZQINIT_CK;
         zq_run_reg <= 1'b1;
         zq_done_o  <= 1'b0;
      end
      else if (ck_rise && zq_run_reg)
      begin
         zq_cnt_reg <= zq_cnt_reg - 10'h001;
         if (zq_cnt_reg == 10'h001)
         begin
            zq_run_reg <= 1'b0;
            zq_done_o  <= 1'b1;
         end
      end
   end

   assign mod_busy_o = (mod_cnt_reg != 10'h000);
   assign ready_o    = dll_locked_o & zq_done_o & ~mod_busy_o;

   //////////////////////////////////////////////////////////////////////////
   // Termination: off in reset and until CKE first registered high
   logic [7:0] ctrl_reg;
   logic       rtt_on;

   assign rtt_on = mr_reg[1][`DDI_MR1_RTT_B0] | mr_reg[1][`DDI_MR1_RTT_B1] |
                   mr_reg[1][`DDI_MR1_RTT_B2];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         term_en_o <= 1'b0;
      else
         term_en_o <= rst_n_f && (state_reg == DDI_ST_INIT || state_reg == DDI_ST_READY)
                      && ctrl_reg[0] && odt_f && rtt_on && !mod_busy_o;
   end

   //////////////////////////////////////////////////////////////////////////
   // Bursts: length from MR0 or A12; the array itself is not modelled here
   ddi_bl_t    bl_code;
   logic       len8_reg, burst_run_reg;
   logic [9:0] start_col_reg;
   logic [2:0] beat_reg;

   assign bl_code = ddi_bl_t'(mr_reg[0][`DDI_MR0_BL_LO +: 2]);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || !rst_n_f)
      begin
         burst_run_reg <= 1'b0;
         len8_reg      <= 1'b1;
         start_col_reg <= '0;
         beat_reg      <= '0;
      end
      else if (edge_on && (cmd == DDI_CMD_READ || cmd == DDI_CMD_WRITE))
      begin
         burst_run_reg <= 1'b1;
         start_col_reg <= addr_f[9:0];
         beat_reg      <= '0;
         unique case (bl_code)
            DDI_BL_FIX8: len8_reg <= 1'b1;
            DDI_BL_OTF:  len8_reg <= addr_f[`DDI_ADDR_OTF_BIT];
            DDI_BL_FIX4: len8_reg <= 1'b0;
            DDI_BL_RSVD: len8_reg <= 1'b1;
         endcase
      end
      else if (ck_rise && burst_run_reg)
      begin
         beat_reg <= beat_reg + 3'h1;
         if (beat_reg == (len8_reg ? 3'h7 : 3'h3))
            burst_run_reg <= 1'b0;
      end
   end

   logic [9:0] col_now;

   ddi_burst_col u_col
   (
      .start_col_i (start_col_reg),
      .len8_i      (len8_reg),
      .beat_i      (beat_reg),
      .col_o       (col_now)
   );

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         burst_col_o <= '0;
      else
         burst_col_o <= col_now;
   end

   // Delayed by one cycle so the flag frames exactly the registered column beats
   logic burst_act_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         burst_act_reg <= 1'b0;
      else
         burst_act_reg <= burst_run_reg;
   end

   assign burst_active_o = burst_act_reg;

   //////////////////////////////////////////////////////////////////////////
   // Status port: one-cycle read latency, unmapped reads return zero
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         ctrl_reg <= `DDI_CTRL_RST;
      else if (reg_wr_i && reg_addr_i == `DDI_REG_CTRL)
         ctrl_reg <= reg_wdata_i;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= '0;
      else if (reg_rd_i)
         unique case (reg_addr_i)
            `DDI_REG_STATUS: reg_rdata_o <= {9'h000, burst_run_reg, mod_busy_o, ready_o,
                                             zq_done_o, dll_locked_o, state_reg};
            `DDI_REG_MR0:    reg_rdata_o <= mr_reg[0];
            `DDI_REG_MR1:    reg_rdata_o <= mr_reg[1];
            `DDI_REG_MR2:    reg_rdata_o <= mr_reg[2];
            `DDI_REG_MR3:    reg_rdata_o <= mr_reg[3];
            `DDI_REG_CTRL:   reg_rdata_o <= {8'h00, ctrl_reg};
            default:         reg_rdata_o <= '0;
         endcase
      else
         reg_rdata_o <= '0;
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   term_in_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_reg == DDI_ST_RESET || state_reg == DDI_ST_CKE_LOW) |=> !term_en_o)
      else $error("termination on before CKE registered high");
   dll_bit_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      mr_reg[0][8] && !mrs_hit && rst_n_f |=> !mr_reg[0][8] && dll_start_reg)
      else $error("DLL reset bit did not self-clear");
   mr_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !mrs_hit && rst_n_f ##1 rst_n_f |-> $stable(mr_reg[2]) && $stable(mr_reg[3]))
      else $error("mode register changed without MRS");
   mr_load_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      mrs_hit && ba_f == 3'b010 |=> mr_reg[2] == $past(addr_f))
      else $error("MR2 not loaded with full value");
   mod_start_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      mrs_hit |=> mod_cnt_reg == 10'h00c && !ready_o)
      else $error("tMOD window not opened by MRS");
   dll_wait_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      dll_start_reg |=> dll_cnt_reg == 10'h200 && !dll_locked_o)
      else $error("DLL lock timer not started at 512");
   ready_cause_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      ready_o |-> zq_done_o && dll_locked_o && mod_cnt_reg == 10'h000)
      else $error("ready without ZQ and DLL waits");
   otf_len_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      edge_on && cmd == DDI_CMD_READ && bl_code == DDI_BL_OTF |=> len8_reg == $past(addr_f[12]))
      else $error("on-the-fly length not taken from A12");
   bc4_len_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      edge_on && cmd == DDI_CMD_WRITE && bl_code == DDI_BL_FIX4 |=> !len8_reg)
      else $error("fixed chop not applied");
   wrap_block_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      burst_run_reg |-> col_now[9:3] == start_col_reg[9:3] &&
                        (len8_reg || col_now[2] == start_col_reg[2]))
      else $error("burst left its column block");

   init_done_c:  cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      state_reg == DDI_ST_INIT ##1 state_reg == DDI_ST_READY);
   mrs_mr0_c:    cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      mrs_hit && ba_f[1:0] == 2'b00 && addr_f[8]);
   burst_otf_c:  cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      burst_run_reg && bl_code == DDI_BL_OTF && !len8_reg);

endmodule : ddi_init_core

// ==== verification/ddi_ctl_model.sv ====
/*
 * Controller-side model that drives the DDR3 command and control pins.
 * Assumes the device samples pins at CK rise; pins change at CK fall.
 */
module ddi_ctl_model #(
   parameter int T_RST_NS = 200000,
   parameter int T_CKE_NS = 500000,
   parameter int TMOD_CK  = 12
)
(
   output logic        ck_o,
   output logic        reset_n_o,
   output logic        cke_o,
   output logic        cs_n_o,
   output logic        ras_n_o,
   output logic        cas_n_o,
   output logic        we_n_o,
   output logic        odt_o,
   output logic [2:0]  ba_o,
   output logic [15:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // CK runs free so it is valid well before CKE rises
   initial
   begin
      ck_o = 1'b0;
      forever #100 ck_o = ~ck_o;
   end

   // ODT may float high in power-up, so the device must still hold termination off
   initial
   begin
      reset_n_o = 1'b0;
      cke_o = 1'b0;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
      odt_o = 1'b1;
      ba_o = 3'h0;
      addr_o = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic idle(input int n);
      repeat (n) @(negedge ck_o);
   endtask : idle

   task automatic power_up();
      #(T_RST_NS);
      @(negedge ck_o);
      reset_n_o <= 1'b1;
      odt_o <= 1'b0;
      #(T_CKE_NS - 200);
      @(negedge ck_o);
      cke_o <= 1'b1;
   endtask : power_up

   // Address flips after the command so a stale capture shows up
   task automatic cmd(input logic [3:0] code, input logic [2:0] bank, input logic [15:0] a);
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= code;
      ba_o <= bank;
      addr_o <= a;
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
      ba_o <= ~bank;
      addr_o <= ~a;
   endtask : cmd

   // Banks are never opened; the tMOD wait also covers tMRD, CL is never changed
   task automatic mrs(input logic [2:0] bank, input logic [15:0] value);
      @(negedge ck_o);
      odt_o <= 1'b0;
      cmd(4'h0, bank, value);
      idle(TMOD_CK);
   endtask : mrs

   task automatic set_odt(input logic v);
      @(negedge ck_o);
      odt_o <= v;
   endtask : set_odt

   task automatic reset_low();
      @(negedge ck_o);
      reset_n_o <= 1'b0;
      cke_o <= 1'b0;
   endtask : reset_low
endmodule : ddi_ctl_model

// ==== verification/tb_ddr3_init_and_mode_register_setup.sv ====
/*
 * Self-checking bench of the DDR3 initialisation block and its controller model.
 * Assumes ddi_map.svh on the include path and ddi_ctl_model compiled first.
 */
`include "ddi_map.svh"
`define CHK(g, e) \
   begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_ddr3_init_and_mode_register_setup;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i;
   logic [2:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i;
   logic [15:0] reg_rdata_o, rdata, addr;
   logic        term_en_o, mod_busy_o, dll_locked_o, zq_done_o, ready_o, burst_active_o;
   logic [9:0]  burst_col_o;
   logic        ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [2:0]  ba;
   int          err_count;
   int          n_compared;

   ddi_ctl_model i_ctl (.ck_o(ck), .reset_n_o(reset_n), .cke_o(cke), .cs_n_o(cs_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .odt_o(odt), .ba_o(ba), .addr_o(addr));

   ddi_init_core i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck),
      .reset_n_i(reset_n), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
      .we_n_i(we_n), .odt_i(odt), .ba_i(ba), .addr_i(addr), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .term_en_o(term_en_o), .mod_busy_o(mod_busy_o),
      .dll_locked_o(dll_locked_o), .zq_done_o(zq_done_o), .ready_o(ready_o),
      .burst_active_o(burst_active_o), .burst_col_o(burst_col_o));

   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic chk_reg(input logic [2:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      rdata = reg_rdata_o;
      `CHK(rdata, e)
   endtask : chk_reg

   task automatic ck_wait(input int n);
      repeat (n) @(negedge ck);
   endtask : ck_wait

   task automatic t_reset();
      chk_reg(`DDI_REG_STATUS, 16'h0000);
      chk_reg(`DDI_REG_CTRL, 16'h0001);
      for (int a = 1; a < 5; a++)
         chk_reg(3'(a), 16'h0000);
      wr(`DDI_REG_MR1, 8'hff);
      chk_reg(`DDI_REG_MR1, 16'h0000);
      chk_reg(3'h7, 16'h0000);
      `CHK(term_en_o, 1'b0)
      $display("test reset done");
   endtask : t_reset

   task automatic t_power();
      fork
         i_ctl.power_up();
         begin
            wait (reset_n === 1'b1);
            ck_wait(4);
            chk_reg(`DDI_REG_STATUS, 16'h0001);
            `CHK(term_en_o, 1'b0)
         end
      join
      ck_wait(4);
      chk_reg(`DDI_REG_STATUS, 16'h0002);
      $display("test power-up done");
   endtask : t_power

   task automatic t_mrs();
      i_ctl.cmd(4'h0, 3'b110, 16'h1234);
      ck_wait(2);
      chk_reg(`DDI_REG_MR2, 16'h0000);
      i_ctl.cmd(4'h0, 3'b010, 16'h0008);
      ck_wait(10);
      `CHK(mod_busy_o, 1'b1)
      ck_wait(3);
      `CHK(mod_busy_o, 1'b0)
      i_ctl.mrs(3'b011, 16'h0004);
      i_ctl.mrs(3'b001, 16'h0044);
      i_ctl.cmd(4'h0, 3'b000, 16'h0571);
      i_ctl.idle(12);
      i_ctl.cmd(4'h6, 3'b000, 16'h0400);
      chk_reg(`DDI_REG_MR2, 16'h0008);
      chk_reg(`DDI_REG_MR3, 16'h0004);
      chk_reg(`DDI_REG_MR1, 16'h0044);
      chk_reg(`DDI_REG_MR0, 16'h0471);
      ck_wait(488);
      `CHK(dll_locked_o, 1'b0)
      ck_wait(15);
      `CHK(dll_locked_o, 1'b1)
      `CHK(zq_done_o, 1'b0)
      `CHK(ready_o, 1'b0)
      ck_wait(15);
      chk_reg(`DDI_REG_STATUS, 16'h001f);
      $display("test mode registers done");
   endtask : t_mrs

   task automatic t_term();
      i_ctl.set_odt(1'b1);
      ck_wait(2);
      `CHK(term_en_o, 1'b1)
      wr(`DDI_REG_CTRL, 8'h00);
      ck_wait(1);
      `CHK(term_en_o, 1'b0)
      wr(`DDI_REG_CTRL, 8'h01);
      i_ctl.set_odt(1'b0);
      ck_wait(2);
      `CHK(term_en_o, 1'b0)
      $display("test termination done");
   endtask : t_term

   task automatic t_burst();
      logic [1:0] code [5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h3};
      logic       otf  [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      // Reads and writes alternate: the length setting must apply to both
      logic [3:0] op   [5] = '{4'h5, 4'h4, 4'h5, 4'h4, 4'h5};
      int         len  [5] = '{8, 4, 4, 8, 8};
      logic [9:0] start;
      logic [9:0] last;
      logic [9:0] col;
      int         got;
      start = 10'h2b5;
      for (int k = 0; k < 5; k++)
      begin
         i_ctl.mrs(3'b000, {14'h011c, code[k]});
         chk_reg(`DDI_REG_MR0, {14'h011c, code[k]});
         got = 0;
         last = 10'h000;
         fork
            i_ctl.cmd(op[k], 3'h0, {3'h0, otf[k], 2'h0, start});
            repeat (160)
            begin
               @(negedge core_clk_i);
               if (burst_active_o === 1'b1 && (got == 0 || burst_col_o !== last))
               begin
                  col = (len[k] == 8) ? {start[9:3], 3'(start[2:0] + got)}
                                      : {start[9:2], 2'(start[1:0] + got)};
                  `CHK(burst_col_o, col)
                  last = burst_col_o;
                  got++;
               end
            end
         join
         `CHK(got, len[k])
         start = start + 10'h0d3;
      end
      $display("test bursts done");
   endtask : t_burst

   task automatic t_pin_reset();
      i_ctl.reset_low();
      ck_wait(3);
      i_ctl.cmd(4'h0, 3'b011, 16'h00ff);
      ck_wait(2);
      chk_reg(`DDI_REG_MR1, 16'h0000);
      chk_reg(`DDI_REG_MR3, 16'h0000);
      chk_reg(`DDI_REG_CTRL, 16'h0001);
      chk_reg(`DDI_REG_STATUS, 16'h0000);
      $display("test pin reset done");
   endtask : t_pin_reset

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      err_count = 0;
      n_compared = 0;
      sys_rst_i = 1'b1;
      reg_addr_i = 3'h0;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_power();
      t_mrs();
      t_term();
      t_burst();
      t_pin_reset();
      stop_test();
   end

   // Whole run needs about 0.9 ms
   initial
   begin
      #1500000;
      err_count++;
      $display("watchdog expired");
      stop_test();
   end
endmodule : tb_ddr3_init_and_mode_register_setup
